// File: pkg/cisa_pkg.sv
// shared constants and types for the compressed branch and multiple-transfer decoder
package cisa_pkg;
    // address arithmetic
    localparam logic [31:0] SWI_VECTOR = 32'h0000_0008;
    localparam logic [31:0] PREFETCH_OFS = 32'h0000_0004;
    localparam logic [31:0] HALF_STEP = 32'h0000_0002;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    // status register layout
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam int STATE_BIT = 5;
    localparam logic [4:0] MODE_SVC = 5'h13;
    // opcode fields
    localparam logic [3:0] OP4_MULTI = 4'hC;
    localparam logic [3:0] OP4_COND = 4'hD;
    localparam logic [4:0] OP5_UNCOND = 5'h1C;
    localparam logic [3:0] OP4_LONG = 4'hF;
    localparam logic [3:0] COND_UNDEF = 4'hE;
    localparam logic [3:0] COND_SWI = 4'hF;
    // pipeline refill after a taken branch: 2 extra cycles, 3 in all
    localparam logic [1:0] REFILL_CYC = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_WB, ST_REFILL} state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic we;
        logic [2:0] idx;
        logic [31:0] data;
    } reg_wr_t;
endpackage

// File: hw/cisa_branch_ldm_decode.sv
// decode and execute of compressed multiple transfer, branch and interrupt formats
`timescale 1ns/1ns
module cisa_branch_ldm_decode
    import cisa_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_I,
    input wire logic [31:0] INSTR_ADDR_I,
    input wire logic [31:0] CURRENT_STATUS_REGISTER_I,
    input wire logic [31:0] LINK_I,
    input wire logic [31:0] REG_RDATA_I,
    input wire logic [31:0] MEM_RDATA_I,
    input wire logic MEM_ACK_I,
    output logic INSTR_READY_O,
    output logic [2:0] REG_RADDR_O,
    output reg_wr_t REG_WR_O,
    output mem_req_t MEM_O,
    output logic PC_WE_O,
    output logic [31:0] PC_O,
    output logic LR_WE_O,
    output logic [31:0] LR_O,
    output logic SAVED_STATUS_REGISTER_WE_O,
    output logic [31:0] SAVED_STATUS_REGISTER_O,
    output logic CURRENT_STATUS_REGISTER_WE_O,
    output logic [31:0] CURRENT_STATUS_REGISTER_O,
    output logic UNDEF_O,
    output logic DONE_O
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_q, rst_n_q;

    // two stages so the release is clean against the clock
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers
    state_t state_q, state_d;
    logic [7:0] list_q, list_d;
    logic [31:0] addr_q, addr_d;
    logic load_q, load_d;
    logic [2:0] base_q, base_d;
    logic [1:0] wait_q, wait_d;
    mem_req_t mem_q, mem_d;
    reg_wr_t regw_q, regw_d;
    logic pc_we_q, pc_we_d, lr_we_q, lr_we_d;
    logic saved_status_register_we_q, saved_status_register_we_d, current_status_register_we_q, current_status_register_we_d;
    logic [31:0] pc_q, pc_d, lr_q, lr_d, saved_status_register_q, saved_status_register_d, current_status_register_q, current_status_register_d;
    logic undef_q, undef_d, done_q, done_d;
    logic [2:0] cur_idx;
    logic [31:0] pc_base, next_addr, cond_ofs, unc_ofs, hi_ofs;
    logic [3:0] cond;
    logic cond_ok;
    logic accept;
    // condition evaluation looks at the flags only, never at register data
    function automatic logic cond_pass(input logic [3:0] c, input logic [31:0] psr);
        logic n, z, cy, v;
        {n, z, cy, v} = {psr[FLAG_N], psr[FLAG_Z], psr[FLAG_C], psr[FLAG_V]};
        case (c)
            4'h0: cond_pass = z;
            4'h1: cond_pass = !z;
            4'h2: cond_pass = cy;
            4'h3: cond_pass = !cy;
            4'h4: cond_pass = n;
            4'h5: cond_pass = !n;
            4'h6: cond_pass = v;
            4'h7: cond_pass = !v;
            4'h8: cond_pass = cy && !z;
            4'h9: cond_pass = !cy || z;
            4'hA: cond_pass = (n == v);
            4'hB: cond_pass = (n != v);
            4'hC: cond_pass = !z && (n == v);
            4'hD: cond_pass = z || (n != v);
            default: cond_pass = 1'b0;
        endcase
    endfunction
    // lowest listed register goes first, so addresses climb with the index
    always_comb begin
        cur_idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (list_q[i]) begin
                cur_idx = 3'(i);
            end
        end
    end
    // offsets widened to the full address before any add
    assign cond = INSTR_I[11:8];
    assign cond_ok = cond_pass(cond, CURRENT_STATUS_REGISTER_I);
    assign pc_base = INSTR_ADDR_I + PREFETCH_OFS;
    assign next_addr = INSTR_ADDR_I + HALF_STEP;
    assign cond_ofs = {{23{INSTR_I[7]}}, INSTR_I[7:0], 1'b0};
    assign unc_ofs = {{20{INSTR_I[10]}}, INSTR_I[10:0], 1'b0};
    assign hi_ofs = {{9{INSTR_I[10]}}, INSTR_I[10:0], 12'h000};
    assign accept = INSTR_VALID_I && INSTR_READY_O;
    // handshake and register file read port are combinational
    assign INSTR_READY_O = (state_q == ST_IDLE);
    assign REG_RADDR_O = (state_q == ST_IDLE) ? INSTR_I[10:8] : cur_idx;
    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        list_d = list_q;
        addr_d = addr_q;
        load_d = load_q;
        base_d = base_q;
        wait_d = wait_q;
        mem_d = mem_q;
        regw_d = '0;
        pc_we_d = 1'b0;
        pc_d = pc_q;
        lr_we_d = 1'b0;
        lr_d = lr_q;
        saved_status_register_we_d = 1'b0;
        saved_status_register_d = saved_status_register_q;
        current_status_register_we_d = 1'b0;
        current_status_register_d = current_status_register_q;
        undef_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    if (INSTR_I[15:12] == OP4_MULTI) begin
                        load_d = INSTR_I[11];
                        base_d = INSTR_I[10:8];
                        list_d = INSTR_I[7:0];
                        addr_d = REG_RDATA_I;
                        state_d = ST_XFER;
                    end else if (INSTR_I[15:12] == OP4_COND) begin
                        if (cond == COND_SWI) begin
                            // comment byte is never looked at
                            lr_we_d = 1'b1;
                            lr_d = next_addr;
                            saved_status_register_we_d = 1'b1;
                            saved_status_register_d = CURRENT_STATUS_REGISTER_I;
                            current_status_register_we_d = 1'b1;
                            current_status_register_d = CURRENT_STATUS_REGISTER_I;
                            current_status_register_d[STATE_BIT] = 1'b0;
                            current_status_register_d[4:0] = MODE_SVC;
                            pc_we_d = 1'b1;
                            pc_d = SWI_VECTOR;
                            wait_d = REFILL_CYC - 2'h1;
                            state_d = ST_REFILL;
                        end else if (cond == COND_UNDEF) begin
                            undef_d = 1'b1;
                            done_d = 1'b1;
                        end else if (cond_ok) begin
                            pc_we_d = 1'b1;
                            pc_d = pc_base + cond_ofs;
                            wait_d = REFILL_CYC - 2'h1;
                            state_d = ST_REFILL;
                        end else begin
                            done_d = 1'b1;
                        end
                    end else if (INSTR_I[15:11] == OP5_UNCOND) begin
                        pc_we_d = 1'b1;
                        pc_d = pc_base + unc_ofs;
                        wait_d = REFILL_CYC - 2'h1;
                        state_d = ST_REFILL;
                    end else if (INSTR_I[15:12] == OP4_LONG) begin
                        if (!INSTR_I[11]) begin
                            lr_we_d = 1'b1;
                            lr_d = pc_base + hi_ofs;
                            done_d = 1'b1;
                        end else begin
                            pc_we_d = 1'b1;
                            // low half is unsigned: the sign already sits in the link value
                            pc_d = LINK_I + {20'h0_0000, INSTR_I[10:0], 1'b0};
                            lr_we_d = 1'b1;
                            lr_d = next_addr | 32'h0000_0001;
                            wait_d = REFILL_CYC - 2'h1;
                            state_d = ST_REFILL;
                        end
                    end
                end
            end
            ST_XFER: begin
                // one word in flight at a time; the bus paces the transfer
                if (mem_q.req) begin
                    if (MEM_ACK_I) begin
                        mem_d.req = 1'b0;
                        if (load_q) begin
                            regw_d = '{we: 1'b1, idx: cur_idx, data: MEM_RDATA_I};
                        end
                        list_d[cur_idx] = 1'b0;
                        addr_d = addr_q + WORD_STEP;
                    end
                end else if (list_q == 8'h00) begin
                    state_d = ST_WB;
                end else begin
                    mem_d = '{req: 1'b1, we: !load_q, addr: addr_q, wdata: REG_RDATA_I};
                end
            end
            ST_WB: begin
                // the trailing internal cycle of the transfer carries the write-back
                regw_d = '{we: 1'b1, idx: base_q, data: addr_q};
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
            ST_REFILL: begin
                // fetch refill keeps taken branches at their full-width length
                if (wait_q == 2'h0) begin
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    wait_d = wait_q - 2'h1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            list_q <= '0;
            addr_q <= '0;
            load_q <= 1'b0;
            base_q <= '0;
            wait_q <= '0;
            mem_q <= '0;
            regw_q <= '0;
            pc_we_q <= 1'b0;
            pc_q <= '0;
            lr_we_q <= 1'b0;
            lr_q <= '0;
            saved_status_register_we_q <= 1'b0;
            saved_status_register_q <= '0;
            current_status_register_we_q <= 1'b0;
            current_status_register_q <= '0;
            undef_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            list_q <= list_d;
            addr_q <= addr_d;
            load_q <= load_d;
            base_q <= base_d;
            wait_q <= wait_d;
            mem_q <= mem_d;
            regw_q <= regw_d;
            pc_we_q <= pc_we_d;
            pc_q <= pc_d;
            lr_we_q <= lr_we_d;
            lr_q <= lr_d;
            saved_status_register_we_q <= saved_status_register_we_d;
            saved_status_register_q <= saved_status_register_d;
            current_status_register_we_q <= current_status_register_we_d;
            current_status_register_q <= current_status_register_d;
            undef_q <= undef_d;
            done_q <= done_d;
        end
    end
    // all data outputs straight from flops
    assign REG_WR_O = regw_q;
    assign MEM_O = mem_q;
    assign PC_WE_O = pc_we_q;
    assign PC_O = pc_q;
    assign LR_WE_O = lr_we_q;
    assign LR_O = lr_q;
    assign SAVED_STATUS_REGISTER_WE_O = saved_status_register_we_q;
    assign SAVED_STATUS_REGISTER_O = saved_status_register_q;
    assign CURRENT_STATUS_REGISTER_WE_O = current_status_register_we_q;
    assign CURRENT_STATUS_REGISTER_O = current_status_register_q;
    assign UNDEF_O = undef_q;
    assign DONE_O = done_q;
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!rst_n_q);
    AST_STORE_WRITES: assert property (state_q == ST_XFER && mem_q.req |-> mem_q.we == !load_q)
        else $error("transfer direction does not follow select bit");
    AST_LOAD_DATA: assert property (state_q == ST_XFER && mem_q.req && MEM_ACK_I && load_q
        |=> regw_q.we && regw_q.data == $past(MEM_RDATA_I))
        else $error("loaded word not written to register");
    AST_WRITE_BACK: assert property (state_q == ST_WB
        |=> regw_q.we && regw_q.idx == $past(base_q) && regw_q.data == $past(addr_q))
        else $error("base write-back missing or wrong");
    AST_ADDR_STEP: assert property (state_q == ST_XFER && mem_q.req && MEM_ACK_I
        |=> addr_q == $past(addr_q) + 32'h0000_0004)
        else $error("transfer address did not advance one word");
    AST_BEQ_TAKEN: assert property (accept && INSTR_I[15:8] == 8'hD0 && CURRENT_STATUS_REGISTER_I[FLAG_Z]
        |=> pc_we_q && pc_q == $past(INSTR_ADDR_I) + 32'h0000_0004
            + {{23{$past(INSTR_I[7])}}, $past(INSTR_I[7:0]), 1'b0})
        else $error("equal branch target wrong");
    AST_BGT_FALL: assert property (accept && INSTR_I[15:8] == 8'hDC
        && (CURRENT_STATUS_REGISTER_I[FLAG_Z] || CURRENT_STATUS_REGISTER_I[FLAG_N] != CURRENT_STATUS_REGISTER_I[FLAG_V]) |=> !pc_we_q && done_q)
        else $error("greater-than branch taken on failing flags");
    AST_SWI_ENTRY: assert property (accept && INSTR_I[15:8] == 8'hDF
        |=> pc_q == 32'h0000_0008 && pc_we_q && current_status_register_q[4:0] == 5'h13 && !current_status_register_q[STATE_BIT]
            && lr_q == $past(INSTR_ADDR_I) + 32'h0000_0002)
        else $error("software interrupt entry wrong");
    AST_UNDEF_TRAP: assert property (accept && INSTR_I[15:8] == 8'hDE
        |=> undef_q && !pc_we_q)
        else $error("condition 1110 not trapped");
    AST_UNCOND: assert property (accept && INSTR_I[15:11] == 5'h1C
        |=> pc_q == $past(INSTR_ADDR_I) + 32'h0000_0004
            + {{20{$past(INSTR_I[10])}}, $past(INSTR_I[10:0]), 1'b0})
        else $error("unconditional branch target wrong");
    AST_LONG_SECOND: assert property (accept && INSTR_I[15:11] == 5'h1F
        |=> lr_q[0] && pc_q == $past(LINK_I)
            + {20'h0_0000, $past(INSTR_I[10:0]), 1'b0})
        else $error("second long-branch half wrong");
    AST_REFILL_LEN: assert property (pc_we_q
        |-> !INSTR_READY_O ##1 !INSTR_READY_O ##1 INSTR_READY_O)
        else $error("taken branch length is not three cycles");
endmodule // cisa_branch_ldm_decode

// File: test/cisa_core_model.sv
// behavioural register file and word memory facing the decoder
`timescale 1ns/1ns
module cisa_core_model
    import cisa_pkg::*;
(
    input wire logic clk_i,
    input wire logic [2:0] raddr_i,
    input wire reg_wr_t reg_wr_i,
    input wire mem_req_t mem_i,
    output logic [31:0] rdata_o,
    output logic [31:0] mem_rdata_o,
    output logic mem_ack_o
);
    logic [31:0] regs [0:7];
    logic [31:0] mem [0:63];
    logic slow;
    int wait_cnt;

    ////////////////////////////////////////////////////////////////////////
    // known start contents so every loaded or stored word is traceable
    initial begin
        for (int i = 0; i < 8; i++) begin
            regs[i] = 32'h0101_0000 + i;
        end
        for (int i = 0; i < 64; i++) begin
            mem[i] = 32'hA5A5_0000 + i;
        end
        slow = 1'b0;
        wait_cnt = 0;
        mem_ack_o = 1'b0;
        mem_rdata_o = 32'h0000_0000;
    end

    // low registers read combinationally, written on the strobe
    assign rdata_o = regs[raddr_i];
    always @(posedge clk_i) begin
        if (reg_wr_i.we) begin
            regs[reg_wr_i.idx] <= reg_wr_i.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory answers one word per request; slow mode stalls three cycles
    // read data is inverted outside the ack cycle so stale values never match
    always @(posedge clk_i) begin
        if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_i.we) begin
                mem[mem_i.addr[7:2]] <= mem_i.wdata;
            end
        end else if (mem_i.req) begin
            if (wait_cnt < (slow ? 3 : 0)) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                mem_ack_o <= 1'b1;
                mem_rdata_o <= mem_i.we ? ~mem_rdata_o : mem[mem_i.addr[7:2]];
            end
        end
    end
endmodule // cisa_core_model

// File: test/testbench.sv
// self-checking bench for the compressed branch and multiple-transfer decoder
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
    import cisa_pkg::*;
    logic MCLK_I = 1'b0;
    logic ARST_N_I = 1'b0;
    logic INSTR_VALID_I = 1'b0;
    logic [15:0] INSTR_I = 16'h0000;
    logic [31:0] INSTR_ADDR_I = 32'h0000_0000;
    logic [31:0] CURRENT_STATUS_REGISTER_I = 32'h0000_0000;
    logic [31:0] LINK_I, REG_RDATA_I, MEM_RDATA_I, PC_O, LR_O, SAVED_STATUS_REGISTER_O, CURRENT_STATUS_REGISTER_O;
    logic MEM_ACK_I, INSTR_READY_O, PC_WE_O, LR_WE_O, SAVED_STATUS_REGISTER_WE_O, CURRENT_STATUS_REGISTER_WE_O, UNDEF_O, DONE_O;
    logic [2:0] REG_RADDR_O;
    reg_wr_t REG_WR_O;
    mem_req_t MEM_O;
    logic s_pc_we, s_lr_we, s_saved_status_register_we, s_current_status_register_we, s_undef;
    logic [31:0] s_pc, s_lr, s_saved_status_register, s_current_status_register, at, exp_pc;
    int cyc, n_mismatch = 0, checked = 0;
    logic tk;

    always #4 MCLK_I = ~MCLK_I;

    cisa_branch_ldm_decode cisa_branch_ldm_decode_inst (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
        .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .INSTR_ADDR_I(INSTR_ADDR_I),
        .CURRENT_STATUS_REGISTER_I(CURRENT_STATUS_REGISTER_I), .LINK_I(LINK_I), .REG_RDATA_I(REG_RDATA_I), .MEM_RDATA_I(MEM_RDATA_I),
        .MEM_ACK_I(MEM_ACK_I), .INSTR_READY_O(INSTR_READY_O), .REG_RADDR_O(REG_RADDR_O),
        .REG_WR_O(REG_WR_O), .MEM_O(MEM_O), .PC_WE_O(PC_WE_O), .PC_O(PC_O), .LR_WE_O(LR_WE_O),
        .LR_O(LR_O), .SAVED_STATUS_REGISTER_WE_O(SAVED_STATUS_REGISTER_WE_O), .SAVED_STATUS_REGISTER_O(SAVED_STATUS_REGISTER_O), .CURRENT_STATUS_REGISTER_WE_O(CURRENT_STATUS_REGISTER_WE_O),
        .CURRENT_STATUS_REGISTER_O(CURRENT_STATUS_REGISTER_O), .UNDEF_O(UNDEF_O), .DONE_O(DONE_O));

    cisa_core_model cisa_core_model_inst (.clk_i(MCLK_I), .raddr_i(REG_RADDR_O),
        .reg_wr_i(REG_WR_O), .mem_i(MEM_O), .rdata_o(REG_RDATA_I), .mem_rdata_o(MEM_RDATA_I),
        .mem_ack_o(MEM_ACK_I));

    // the core hands the link register straight back for the second long-branch half
    assign LINK_I = LR_O;

    ////////////////////////////////////////////////////////////////////////
    // reference condition evaluation over n z c v
    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        {n, z, cy, v} = f;
        case (c)
            4'h0: return z;
            4'h1: return !z;
            4'h2: return cy;
            4'h3: return !cy;
            4'h4: return n;
            4'h5: return !n;
            4'h6: return v;
            4'h7: return !v;
            4'h8: return cy && !z;
            4'h9: return !cy || z;
            4'hA: return n == v;
            4'hB: return n != v;
            4'hC: return !z && (n == v);
            default: return z || (n != v);
        endcase
    endfunction

    // remember every pc, lr and status write strobe and any undef seen while an instruction runs
    task automatic sample;
        if (PC_WE_O === 1'b1) begin s_pc_we = 1'b1; s_pc = PC_O; end
        if (LR_WE_O === 1'b1) begin s_lr_we = 1'b1; s_lr = LR_O; end
        if (SAVED_STATUS_REGISTER_WE_O === 1'b1) begin s_saved_status_register_we = 1'b1; s_saved_status_register = SAVED_STATUS_REGISTER_O; end
        if (CURRENT_STATUS_REGISTER_WE_O === 1'b1) begin s_current_status_register_we = 1'b1; s_current_status_register = CURRENT_STATUS_REGISTER_O; end
        if (UNDEF_O === 1'b1) s_undef = 1'b1;
    endtask

    // offer one opcode, then follow it until completion; cyc counts from the take edge
    task automatic exec(input logic [15:0] op, input logic [31:0] addr);
        int k;
        k = 0;
        @(negedge MCLK_I);
        while (INSTR_READY_O !== 1'b1 && k < 100) begin
            @(negedge MCLK_I);
            k++;
        end
        INSTR_I = op;
        INSTR_ADDR_I = addr;
        INSTR_VALID_I = 1'b1;
        @(negedge MCLK_I);
        INSTR_VALID_I = 1'b0;
        {s_pc_we, s_lr_we, s_saved_status_register_we, s_current_status_register_we, s_undef} = '0;
        cyc = 1;
        while (DONE_O !== 1'b1 && cyc < 200) begin
            sample();
            @(negedge MCLK_I);
            cyc++;
        end
        sample();
        `CHK(DONE_O, 1'b1)
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // whole run is a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge MCLK_I);
        n_mismatch++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge MCLK_I);
        ARST_N_I = 1'b1;
        repeat (3) @(posedge MCLK_I);
        // every defined condition against four flag patterns, extreme offsets
        at = 32'h0000_1000;
        for (int c = 0; c < 14; c++) begin
            for (int f = 0; f < 16; f += 5) begin
                CURRENT_STATUS_REGISTER_I = {f[3:0], 28'h000_0030};
                tk = cond_ok(c[3:0], f[3:0]);
                exec({4'hD, c[3:0], (c[0] ? 8'h80 : 8'h7F)}, at);
                exp_pc = at + 32'h4 + (c[0] ? 32'hFFFF_FF00 : 32'h0000_00FE);
                `CHK(s_pc_we, tk)
                if (tk) `CHK(s_pc, exp_pc)
                `CHK(cyc, tk ? 3 : 1)
                `CHK(s_current_status_register_we, 1'b0)
            end
        end
        exec(16'hDE12, at);
        `CHK({s_undef, s_pc_we}, 2'b10)
        // software interrupt with both extremes of the comment field
        CURRENT_STATUS_REGISTER_I = 32'h6000_0030;
        for (int m = 0; m < 2; m++) begin
            exec({8'hDF, (m ? 8'hFF : 8'h00)}, 32'h0000_2000);
            `CHK({s_pc_we, s_pc}, {1'b1, SWI_VECTOR})
            `CHK({s_lr_we, s_lr}, {1'b1, 32'h0000_2002})
            `CHK({s_saved_status_register_we, s_saved_status_register}, {1'b1, CURRENT_STATUS_REGISTER_I})
            `CHK(s_current_status_register, {CURRENT_STATUS_REGISTER_I[31:6], 1'b0, MODE_SVC})
            `CHK(cyc, 3)
        end
        // unconditional branch onto itself and to the far positive end
        exec(16'hE7FE, at);
        `CHK(s_pc, at)
        exec(16'hE3FF, at);
        `CHK(s_pc, at + 32'h0000_0802)
        // long branch pair, negative upper half
        at = 32'h0040_0000;
        exec(16'hF7FF, at);
        `CHK({s_lr_we, s_lr, s_pc_we}, {1'b1, at + 32'hFFFF_F004, 1'b0})
        `CHK(cyc, 1)
        exec(16'hF810, at + 32'h2);
        `CHK(s_pc, at + 32'hFFFF_F024)
        `CHK(s_lr, at + 32'h0000_0005)
        // second half with the top offset bit set must not borrow from the link value
        exec(16'hFC00, at + 32'h2);
        `CHK(s_pc, at + 32'h0000_0805)
        // load r0,r2 from base r1 with a prompt memory
        cisa_core_model_inst.regs[1] = 32'h0000_0040;
        exec(16'hC905, at);
        @(negedge MCLK_I);
        `CHK(cisa_core_model_inst.regs[0], 32'hA5A5_0010)
        `CHK(cisa_core_model_inst.regs[2], 32'hA5A5_0011)
        `CHK(cisa_core_model_inst.regs[1], 32'h0000_0048)
        // store r4-r7 from base r3 with a stalling memory
        cisa_core_model_inst.slow = 1'b1;
        cisa_core_model_inst.regs[3] = 32'h0000_0080;
        exec(16'hC3F0, at);
        @(negedge MCLK_I);
        for (int r = 4; r < 8; r++) begin
            `CHK(cisa_core_model_inst.mem[28 + r], 32'h0101_0000 + r)
        end
        `CHK(cisa_core_model_inst.regs[3], 32'h0000_0090)
        // empty list leaves the base as it was
        exec(16'hCB00, at);
        @(negedge MCLK_I);
        `CHK(cisa_core_model_inst.regs[3], 32'h0000_0090)
        report_and_stop();
    end
endmodule // testbench
